// ---- hdl/dspc_clipper.sv ----
// Output clipper: 28-bit core word saturated to a 24-bit sample
`timescale 1ns/1ps
module dspc_clipper (
  input  wire logic  mclk,
  input  wire logic  reset,
  dspc_clip_if.clip  cif
);
  localparam int CW = dspc_pkg::CORE_W;

  logic signed [dspc_pkg::SAMPLE_W-1:0] clip_word_reg;
  logic signed [dspc_pkg::SAMPLE_W-1:0] clip_word_next;
  logic                                 clip_valid_reg;
  logic signed [dspc_pkg::CORE_W-1:0]   lim_hi;
  logic signed [dspc_pkg::CORE_W-1:0]   lim_lo;

  // Limits widened to the core word for comparison
  assign lim_hi = CW'(dspc_pkg::OUT_MAX);
  assign lim_lo = CW'(dspc_pkg::OUT_MIN);

  // Saturate rather than wrap, so a hot signal keeps its sign
  always_comb begin
    if (cif.core_word > lim_hi) begin
      clip_word_next = dspc_pkg::OUT_MAX; // see RULE_12
    end else if (cif.core_word < lim_lo) begin
      clip_word_next = dspc_pkg::OUT_MIN; // see RULE_12
    end else begin
      clip_word_next = cif.core_word[dspc_pkg::SAMPLE_W-1:0]; // see RULE_07
    end
  end

  // Register the clipped word on each core result
  always_ff @(posedge mclk) begin
    if (reset) begin
      clip_word_reg  <= '0;
      clip_valid_reg <= 1'b0;
    end else begin
      clip_valid_reg <= cif.core_valid;
      if (cif.core_valid) begin
        clip_word_reg <= clip_word_next;
      end
    end
  end

  assign cif.clip_word  = clip_word_reg;
  assign cif.clip_valid = clip_valid_reg;

  a_clip_high : assert property (@(posedge mclk) disable iff (reset) // see RULE_12
    cif.core_valid && (cif.core_word > lim_hi) |=> cif.clip_word == dspc_pkg::OUT_MAX)
    else $error("clipper wrapped a positive overload");
  a_clip_low : assert property (@(posedge mclk) disable iff (reset) // see RULE_12
    cif.core_valid && (cif.core_word < lim_lo) |=> cif.clip_word == dspc_pkg::OUT_MIN)
    else $error("clipper wrapped a negative overload");
  a_clip_pass : assert property (@(posedge mclk) disable iff (reset) // see RULE_07
    cif.core_valid && (cif.core_word <= lim_hi) && (cif.core_word >= lim_lo)
    |=> cif.clip_valid && (cif.clip_word == $past(cif.core_word[dspc_pkg::SAMPLE_W-1:0])))
    else $error("in-range word altered by clipper");
endmodule

// ---- hdl/dspc_datapath.sv ----
// Numeric datapath of the audio core: sign extension, 5.23 MAC, period sequencer
`timescale 1ns/1ps
// Behaviour
// RULE_01 - Samples enter and leave 24 bits wide; carried inside as 28 bits.
// RULE_02 - Four headroom bits above the sample range allow 24 dB gain unclipped.
// RULE_03 - Data and parameters share one two's-complement 5.23 fixed-point format.
// RULE_04 - Linear range runs from -16.0 to +16.0 less one LSB.
// RULE_05 - Processing uses 56-bit double-precision products and accumulation.
// RULE_06 - Input words up to 24 bits are sign-extended to 28 bits.
// RULE_07 - Clipper drops top four bits giving 24-bit output within -1.0 to +1.0-LSB.
// RULE_08 - 1024 instruction cycles per sample, all executed every sample period.
// RULE_09 - A rate setting shortens the cycle count for double or quad rate.
// RULE_10 - After reset the default path passes input to output, outputs muted.
// RULE_11 - Controller pads 28-bit parameters with four leading zeros to four bytes.
// RULE_12 - Out-of-range outputs saturate to the nearest limit, keeping the sign.
module dspc_datapath (
  input  wire logic                                 mclk,
  input  wire logic                                 reset,
  input  wire logic [dspc_pkg::SAMPLE_W-1:0]        sample_in,
  input  wire logic                                 sample_in_valid,
  input  wire logic signed [dspc_pkg::CORE_W-1:0]   gain_coef,
  input  wire logic [1:0]                           rate_sel,
  input  wire logic                                 unmute,
  output logic      [dspc_pkg::SAMPLE_W-1:0]        sample_out,
  output logic                                      sample_out_valid,
  output logic                                      period_tick,
  output logic                                      muted
);
  localparam int CW = dspc_pkg::CORE_W;
  localparam int AW = dspc_pkg::ACC_W;

  logic signed [CW-1:0]          in_word_reg;
  logic signed [CW-1:0]          in_word_next;
  logic [dspc_pkg::CNT_W-1:0]    instr_cnt_reg;
  logic [dspc_pkg::CNT_W-1:0]    instr_last;
  logic                          period_end;
  logic signed [AW-1:0]          acc_reg;
  logic signed [AW-1:0]          acc_next;
  logic signed [AW-1:0]          acc_shift;
  logic signed [CW-1:0]          core_word_reg;
  logic signed [CW-1:0]          core_word_next;
  logic                          core_valid_reg;
  logic                          mute_reg;
  logic [dspc_pkg::SAMPLE_W-1:0] sample_out_reg;
  logic                          sample_out_valid_reg;
  logic                          period_tick_reg;
  logic                          unity_reg;
  logic signed [CW-1:0]          unity_src_reg;
  dspc_clip_if                   clip_bus ();

  // Sign-extend the port sample into the core word
  assign in_word_next = {{dspc_pkg::HEAD_W{sample_in[dspc_pkg::SAMPLE_W-1]}}, // see RULE_02
                         sample_in}; // see RULE_06

  // Latest input sample, held for the whole period
  always_ff @(posedge mclk) begin
    if (reset) begin
      in_word_reg <= '0;
    end else if (sample_in_valid) begin
      in_word_reg <= in_word_next; // see RULE_01
    end
  end

  // Cycles per sample from the rate setting; unused code falls back to full rate
  always_comb begin
    case (rate_sel)
      dspc_pkg::DSPC_RATE_DOUBLE: instr_last = dspc_pkg::INSTR_DBL - 11'h001;  // see RULE_09
      dspc_pkg::DSPC_RATE_QUAD:   instr_last = dspc_pkg::INSTR_QUAD - 11'h001; // see RULE_09
      default:                    instr_last = dspc_pkg::INSTR_FULL - 11'h001; // see RULE_08
    endcase
  end

  // A rate change that leaves the count at or past the new last instruction ends the period at once rather than overrunning
  assign period_end = (instr_cnt_reg >= instr_last);

  // Free-running instruction counter, wraps once per sample period
  always_ff @(posedge mclk) begin
    if (reset) begin
      instr_cnt_reg <= dspc_pkg::CNT_RESET;
    end else if (period_end) begin
      instr_cnt_reg <= dspc_pkg::CNT_RESET; // see RULE_08
    end else begin
      instr_cnt_reg <= instr_cnt_reg + 11'h001;
    end
  end

  // Full 28x28 product kept at 56 bits, never rounded early
  assign acc_next = AW'(in_word_reg * gain_coef); // see RULE_05

  always_ff @(posedge mclk) begin
    if (reset) begin
      acc_reg <= '0;
    end else if (instr_cnt_reg == dspc_pkg::CNT_RESET) begin
      acc_reg <= acc_next; // see RULE_05
    end
  end

  // Assertion helper: operands of this period's product, so the unity
  // check compares against what was really multiplied, not a newer sample
  always_ff @(posedge mclk) begin
    if (reset) begin
      unity_reg     <= 1'b0;
      unity_src_reg <= '0;
    end else if (instr_cnt_reg == dspc_pkg::CNT_RESET) begin
      unity_reg     <= (gain_coef == dspc_pkg::COEF_ONE);
      unity_src_reg <= in_word_reg;
    end
  end

  // Back to 5.23, saturated at the ends of the -16..+16 range
  assign acc_shift = acc_reg >>> dspc_pkg::FRAC_W;

  always_comb begin
    if (acc_shift > AW'(dspc_pkg::CORE_MAX)) begin
      core_word_next = dspc_pkg::CORE_MAX; // see RULE_04
    end else if (acc_shift < AW'(dspc_pkg::CORE_MIN)) begin
      core_word_next = dspc_pkg::CORE_MIN; // see RULE_04
    end else begin
      core_word_next = acc_shift[CW-1:0]; // see RULE_03
    end
  end

  // Core result once per period, at the last instruction
  always_ff @(posedge mclk) begin
    if (reset) begin
      core_word_reg  <= '0;
      core_valid_reg <= 1'b0;
    end else begin
      core_valid_reg <= period_end;
      if (period_end) begin
        core_word_reg <= core_word_next;
      end
    end
  end

  assign clip_bus.core_word  = core_word_reg;
  assign clip_bus.core_valid = core_valid_reg;

  dspc_clipper u_clipper (
    .mclk  (mclk),
    .reset (reset),
    .cif   (clip_bus)
  );

  // Muted from reset until the controller releases it
  always_ff @(posedge mclk) begin
    if (reset) begin
      mute_reg <= dspc_pkg::MUTE_RESET; // see RULE_10
    end else if (unmute) begin
      mute_reg <= 1'b0;
    end
  end

  // Output stage; a muted output still delivers its strobe so downstream stays timed
  always_ff @(posedge mclk) begin
    if (reset) begin
      sample_out_reg       <= '0;
      sample_out_valid_reg <= 1'b0;
      period_tick_reg      <= 1'b0;
    end else begin
      sample_out_valid_reg <= clip_bus.clip_valid;
      period_tick_reg      <= period_end;
      if (clip_bus.clip_valid) begin
        sample_out_reg <= mute_reg ? '0 : clip_bus.clip_word; // see RULE_10
      end
    end
  end

  assign sample_out       = sample_out_reg;
  assign sample_out_valid = sample_out_valid_reg;
  assign period_tick      = period_tick_reg;
  assign muted            = mute_reg;

  default clocking dspc_cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_period_last;
    period_end && $stable(rate_sel);
  endsequence
  sequence s_unity_hold;
    unity_reg;
  endsequence

  // Input capture and period sequencing
  a_sign_extend : assert property ( // see RULE_06
    sample_in_valid |=> in_word_reg == {{4{$past(sample_in[23])}}, $past(sample_in)})
    else $error("input sample not sign-extended to core width");
  a_in_hold : assert property ( // see RULE_01
    !sample_in_valid |=> $stable(in_word_reg))
    else $error("input word changed without a valid strobe");
  a_full_period : assert property ( // see RULE_08
    (rate_sel == 2'b00) && (instr_cnt_reg == 11'h3ff) |=> instr_cnt_reg == 11'h000)
    else $error("full-rate period is not 1024 cycles");
  a_rate_period : assert property ( // see RULE_09
    (rate_sel == 2'b10) && $stable(rate_sel) |-> instr_cnt_reg <= 11'h0ff)
    else $error("quad-rate period exceeds 256 cycles");
  a_dbl_period : assert property ( // see RULE_09
    (rate_sel == 2'b01) && $stable(rate_sel) |-> instr_cnt_reg <= 11'h1ff)
    else $error("double-rate period exceeds 512 cycles");
  a_tick_follows : assert property (period_end |=> period_tick) // see RULE_08
    else $error("period tick missing after the last instruction");
  a_tick_pulse : assert property (period_tick |=> !period_tick) // see RULE_08
    else $error("period tick longer than one cycle");
  // Arithmetic
  a_double_mac : assert property ( // see RULE_05
    instr_cnt_reg == 11'h000 |=> acc_reg == $past(in_word_reg) * $past(gain_coef))
    else $error("product not kept at 56 bits");
  a_acc_hold : assert property ( // see RULE_05
    instr_cnt_reg != 11'h000 |=> $stable(acc_reg))
    else $error("product changed in mid-period");
  a_core_range : assert property ( // see RULE_04
    s_period_last ##0 (acc_shift > AW'(dspc_pkg::CORE_MAX))
    |=> core_valid_reg && (core_word_reg == dspc_pkg::CORE_MAX))
    else $error("core result wrapped instead of saturating");
  a_headroom : assert property ( // see RULE_02
    s_unity_hold ##0 s_period_last |=> core_word_reg == unity_src_reg)
    else $error("unity path lost headroom or changed the sample");
  // Output stage
  a_mute_default : assert property ( // see RULE_10
    mute_reg && clip_bus.clip_valid |=> sample_out_valid && (sample_out == '0))
    else $error("muted output carried a sample");
  a_mute_sticky : assert property (!mute_reg |=> !mute_reg) // see RULE_10
    else $error("mute returned without a reset");
  a_out_latency : assert property (s_period_last |-> ##3 sample_out_valid) // see RULE_01
    else $error("output sample not delivered three cycles after period end");
  a_valid_pulse : assert property (sample_out_valid |=> !sample_out_valid) // see RULE_08
    else $error("output strobe longer than one cycle");
  a_out_hold : assert property (!clip_bus.clip_valid |=> $stable(sample_out)) // see RULE_01
    else $error("output sample changed between strobes");
endmodule

// ---- shared/dspc_clip_if.sv ----
// Link between the core result register and the output clipper
`timescale 1ns/1ps
interface dspc_clip_if;
  logic signed [dspc_pkg::CORE_W-1:0]   core_word;
  logic                                 core_valid;
  logic signed [dspc_pkg::SAMPLE_W-1:0] clip_word;
  logic                                 clip_valid;
  modport core (output core_word, output core_valid, input clip_word, input clip_valid);
  modport clip (input core_word, input core_valid, output clip_word, output clip_valid);
endinterface

// ---- shared/dspc_pkg.sv ----
// Constants for the numeric datapath of the audio signal processor core
package dspc_pkg;
  localparam int SAMPLE_W = 24;              // Port sample width
  localparam int HEAD_W   = 4;               // Headroom bits, about 24 dB
  localparam int CORE_W   = SAMPLE_W + HEAD_W; // Core word, 5.23
  localparam int FRAC_W   = 23;              // Fractional bits of 5.23
  localparam int ACC_W    = 2 * CORE_W;      // Double precision
  localparam int CNT_W    = 11;
  // Instruction cycles per sample for each rate setting
  localparam logic [CNT_W-1:0] INSTR_FULL = 11'h0400;
  localparam logic [CNT_W-1:0] INSTR_DBL  = 11'h0200;
  localparam logic [CNT_W-1:0] INSTR_QUAD = 11'h0100;
  localparam logic [CNT_W-1:0] CNT_RESET  = 11'h0000;
  // Extremes of the core word and of the clipped output
  localparam logic signed [CORE_W-1:0]   CORE_MAX = 28'h7ff_ffff;
  localparam logic signed [CORE_W-1:0]   CORE_MIN = 28'h800_0000;
  localparam logic signed [SAMPLE_W-1:0] OUT_MAX  = 24'h7f_ffff;
  localparam logic signed [SAMPLE_W-1:0] OUT_MIN  = 24'h80_0000;
  localparam logic signed [CORE_W-1:0]   COEF_ONE = 28'h080_0000;
  localparam logic MUTE_RESET = 1'b1;
  typedef enum logic [1:0] {
    DSPC_RATE_FULL,
    DSPC_RATE_DOUBLE,
    DSPC_RATE_QUAD
  } dspc_rate_t;
endpackage

// ---- testbench/dspc_port_model.sv ----
// Serial input port model: one input word per sample period
`timescale 1ns/1ps
module dspc_port_model (
  input  wire logic                          mclk,
  input  wire logic                          reset,
  input  wire logic                          period_tick,
  input  wire logic [dspc_pkg::SAMPLE_W-1:0] src_word,
  output logic      [dspc_pkg::SAMPLE_W-1:0] sample_in,
  output logic                               sample_in_valid
);
  logic [dspc_pkg::SAMPLE_W-1:0] last_reg;
  // Word goes out just after a period starts; between words the line shows garbage
  always_ff @(posedge mclk) begin
    if (reset) begin
      sample_in_valid <= 1'b0;
      sample_in       <= 24'h00_0000;
      last_reg        <= 24'h00_0000;
    end else if (period_tick) begin
      sample_in_valid <= 1'b1;
      sample_in       <= src_word;
      last_reg        <= src_word;
    end else begin
      sample_in_valid <= 1'b0;
      sample_in       <= ~last_reg; // Inverse, so stale data is never mistaken
    end
  end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the audio core datapath
`timescale 1ns/1ps
module testbench;
  logic               mclk;
  logic               reset;
  logic        [23:0] src_word;
  logic        [23:0] sample_in;
  logic               sample_in_valid;
  logic signed [27:0] gain_coef;
  logic        [1:0]  rate_sel;
  logic               unmute;
  logic        [23:0] sample_out;
  logic               sample_out_valid;
  logic               period_tick;
  logic               muted;
  int                 err_total;
  int                 total_checks;

  dspc_datapath dspc_datapath_inst (.mclk(mclk), .reset(reset), .sample_in(sample_in),
    .sample_in_valid(sample_in_valid), .gain_coef(gain_coef), .rate_sel(rate_sel),
    .unmute(unmute), .sample_out(sample_out), .sample_out_valid(sample_out_valid),
    .period_tick(period_tick), .muted(muted));
  dspc_port_model dspc_port_model_inst (.mclk(mclk), .reset(reset), .period_tick(period_tick),
    .src_word(src_word), .sample_in(sample_in), .sample_in_valid(sample_in_valid));

  // 100 ns clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Reference: 28-bit sign extension, 56-bit product, truncate to 5.23, saturate to 24
  function automatic logic [23:0] model(input logic [23:0] s, input logic [27:0] g);
    logic signed [55:0] q;
    q = ($signed({{4{s[23]}}, s}) * $signed(g)) >>> 23;
    if (q > 56'sh00_0000_007f_ffff) return 24'h7f_ffff;
    if (q < -56'sh00_0000_0080_0000) return 24'h80_0000;
    return q[23:0];
  endfunction

  // Bounded wait; leaves us 1 ns after the edge that shows the tick
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (period_tick !== 1'b1 && n < 1100);
  endtask

  // One word through the core; result shows two periods after the word is sent
  task automatic run_one(input logic [23:0] s, input logic [27:0] g, input logic [23:0] exp);
    int          n;
    int          k;
    logic [31:0] coef_word;
    coef_word = {4'h0, g}; // Controller form: four zero bits above the 28-bit word
    @(posedge mclk);
    src_word  <= s;
    gain_coef <= coef_word[27:0];
    repeat (3) wait_tick(n);
    k = 0;
    while (sample_out_valid !== 1'b1 && k < 4) begin
      @(posedge mclk);
      #1;
      k++;
    end
    check({23'h00_0000, sample_out_valid}, 24'h00_0001, "output strobe");
    check(sample_out, exp, "output sample");
  endtask

  task automatic test_mute();
    check({23'h00_0000, muted}, 24'h00_0001, "muted after reset");
    run_one(24'h40_0000, 28'h080_0000, 24'h00_0000);
    @(posedge mclk);
    unmute <= 1'b1;
    @(posedge mclk);
    unmute <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check({23'h00_0000, muted}, 24'h00_0000, "mute cleared");
    run_one(24'h40_0000, 28'h080_0000, 24'h40_0000);
    $display("test mute done");
  endtask

  task automatic test_pass();
    logic [23:0] vals [5] = '{24'h7f_ffff, 24'h80_0000, 24'h00_0001, 24'hff_ffff, 24'h12_3456};
    foreach (vals[i]) run_one(vals[i], 28'h080_0000, vals[i]);
    $display("test pass-through done");
  endtask

  task automatic test_gain();
    run_one(24'h08_0000, 28'h780_0000, model(24'h08_0000, 28'h780_0000));
    run_one(24'h40_0000, 28'h200_0000, 24'h7f_ffff);
    run_one(24'hc0_0000, 28'h200_0000, 24'h80_0000);
    run_one(24'h80_0000, 28'hf80_0000, 24'h7f_ffff);
    run_one(24'h00_0003, 28'h040_0000, model(24'h00_0003, 28'h040_0000));
    run_one(24'hff_fffd, 28'h040_0000, model(24'hff_fffd, 28'h040_0000));
    run_one(24'h00_0001, 28'h7ff_ffff, model(24'h00_0001, 28'h7ff_ffff));
    run_one(24'h7f_ffff, 28'h800_0000, 24'h80_0000);
    run_one(24'h7f_ffff, 28'h7ff_ffff, 24'h7f_ffff);
    run_one(24'h80_0000, 28'h800_0000, 24'h7f_ffff);
    $display("test gain done");
  endtask

  // Settle one period after each change, then time the next whole one
  task automatic test_rate();
    int exp_len [4] = '{1024, 512, 256, 1024};
    int n;
    for (int r = 0; r < 4; r++) begin
      @(posedge mclk);
      rate_sel <= r[1:0];
      wait_tick(n);
      wait_tick(n);
      wait_tick(n);
      check(n[23:0], exp_len[r][23:0], "period length");
    end
    rate_sel <= 2'h2;
    $display("test rate done");
  endtask

  // Watchdog: the tests need about 22k cycles
  initial begin
    #(40_000 * 100);
    err_total++;
    $display("FAIL t=%0t watchdog expired", $time);
    final_report();
  end

  // Main sequence; quad rate keeps periods short
  initial begin
    err_total    = 0;
    total_checks = 0;
    reset        = 1'b1;
    src_word     = 24'h00_0000;
    gain_coef    = 28'h080_0000;
    rate_sel     = 2'h2;
    unmute       = 1'b0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
    check(sample_out, 24'h00_0000, "output after reset");
    test_mute();
    test_pass();
    test_gain();
    test_rate();
    final_report();
  end
endmodule
